/* File: dv/cpt_i2c_host.sv */
// Serial bus host model for the charge pump control block
`timescale 1ns/1ps
`default_nettype none
module cpt_i2c_host (
	input  wire logic sys_clk,
	input  wire logic sdaOe,
	output logic      scl,
	output logic      sdaIn
);
	logic pullLow;

	// ****************************************
	// Open-drain wire with pull-up
	// ****************************************
	assign sdaIn = !(pullLow || sdaOe);

	initial begin
		scl = 1'b1;
		pullLow = 1'b0;
	end

	// ****************************************
	// Bus cycles
	// ****************************************
	task automatic qtr();
		repeat (2) @(posedge sys_clk);
		#10;
	endtask

	// Low for six cycles, high for two: an 800 ns bit
	task automatic bitio(input logic b, output logic r);
		repeat (5) @(posedge sys_clk);
		#10;
		pullLow = !b;
		@(posedge sys_clk);
		#10;
		scl = 1'b1;
		@(posedge sys_clk);
		#10;
		r = sdaIn;
		@(posedge sys_clk);
		#10;
		scl = 1'b0;
	endtask

	// Byte MSB first, then the ninth bit
	task automatic xfer(input logic [7:0] dOut, input logic ackOut, output logic [7:0] dIn, output logic ackIn);
		for (int i = 7; i >= 0; i--) begin
			bitio(dOut[i], dIn[i]);
		end
		bitio(ackOut, ackIn);
	endtask

	// Start then address with direction bit
	task automatic start(input logic [6:0] addr, input logic rd, output logic ack);
		logic [7:0] unused;
		qtr();
		pullLow = 1'b1;
		qtr();
		scl = 1'b0;
		xfer({addr, rd}, 1'b1, unused, ack);
	endtask

	task automatic stop();
		qtr();
		pullLow = 1'b1;
		qtr();
		scl = 1'b1;
		qtr();
		pullLow = 1'b0;
		qtr();
	endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking testbench of the charge pump control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       sys_clk, rstn, shutdownN, scl, sdaIn, sdaOut, sdaOe, ack;
	logic       aboveTgt, belowHyst, belowVm1, aboveVin, sinkLow, cur400, cur300;
	logic       pumpOn, pumpPhaseTick, targetIsFlash, standby;
	logic [1:0] pumpGain, flashTimeoutSel;
	logic [2:0] chanEnable, flashLevelCode, flashVoltCode;
	logic [3:0] torchLevelCode;
	logic [7:0] b0, b1, b2, b3;
	int         mismatches, comparisons, cycles;

	cpt_ctrl cpt_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn), .shutdownN(shutdownN), .scl(scl), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .outAboveTarget(aboveTgt), .outBelowHyst(belowHyst),
		.outBelowVinMinus1V(belowVm1), .outAboveVin(aboveVin), .sinkBelowDropout(sinkLow),
		.inCurBelow400(cur400), .inCurBelow300(cur300), .pumpOn(pumpOn), .pumpGain(pumpGain),
		.pumpPhaseTick(pumpPhaseTick), .chanEnable(chanEnable), .torchLevelCode(torchLevelCode),
		.flashLevelCode(flashLevelCode), .targetIsFlash(targetIsFlash), .flashVoltCode(flashVoltCode),
		.flashTimeoutSel(flashTimeoutSel), .standby(standby));
	cpt_i2c_host cpt_i2c_host_inst (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));

	// ****************************************
	// Helpers
	// ****************************************
	always #50 sys_clk = ~sys_clk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask

	// Address, control byte, optionally flash then torch byte
	task automatic wr(input logic [7:0] c, input logic [7:0] f, input logic [7:0] t, input logic full);
		cpt_i2c_host_inst.start(7'h28, 1'b0, ack);
		check(ack, 8'h00);
		cpt_i2c_host_inst.xfer(c, 1'b1, b0, ack);
		if (full) begin
			cpt_i2c_host_inst.xfer(f, 1'b1, b0, ack);
			cpt_i2c_host_inst.xfer(t, 1'b1, b0, ack);
		end
		check(ack, 8'h00);
		cpt_i2c_host_inst.stop();
		wt(20);
	endtask

	task automatic rd3(input logic [7:0] c, input logic [7:0] f, input logic [7:0] t, input logic [7:0] s);
		cpt_i2c_host_inst.start(7'h28, 1'b1, ack);
		cpt_i2c_host_inst.xfer(8'hFF, 1'b0, b0, ack);
		cpt_i2c_host_inst.xfer(8'hFF, 1'b0, b1, ack);
		cpt_i2c_host_inst.xfer(8'hFF, 1'b0, b2, ack);
		cpt_i2c_host_inst.xfer(8'hFF, 1'b1, b3, ack);
		cpt_i2c_host_inst.stop();
		check(b0, c);
		check(b1, f);
		check(b2, t);
		check(b3, s);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_regs();
		check({pumpOn, chanEnable, torchLevelCode}, 8'h00);
		check({sdaOut, sdaOe, standby}, 8'h00);
		check(pumpGain, cpt_pkg::G1X);
		wr(8'hB8, 8'h00, 8'hFE, 1'b1);
		check(torchLevelCode, 8'h0F);
		check(chanEnable, 8'h07);
		check(targetIsFlash, 8'h00);
		check(pumpGain, cpt_pkg::G1X);
		rd3(8'hB8, 8'h00, 8'hFE, 8'h00);
		cpt_i2c_host_inst.start(7'h29, 1'b0, ack);
		check(ack, 8'h01);
		cpt_i2c_host_inst.stop();
		aboveTgt = 1'b1;
		belowHyst = 1'b0;
		wt(12);
		check(pumpOn, 8'h00);
		aboveTgt = 1'b0;
		wt(12);
		check(pumpOn, 8'h00);
		belowHyst = 1'b1;
		wt(12);
		check(pumpOn, 8'h01);
	endtask

	task automatic s_auto();
		belowVm1 = 1'b0;
		wr(8'hA0, 8'h00, 8'h00, 1'b0);
		check(chanEnable, 8'h00);
		check({pumpOn, pumpGain}, {6'h01, cpt_pkg::G1X});
		cur400 = 1'b1;
		wt(12);
		check(pumpGain, cpt_pkg::G15X);
		cur300 = 1'b1;
		wt(12);
		check(pumpGain, cpt_pkg::G15X);
		aboveVin = 1'b1;
		wt(12);
		check(pumpGain, cpt_pkg::G2X);
		aboveTgt = 1'b1;
		belowHyst = 1'b0;
		wt(12);
		check({pumpOn, chanEnable}, 8'h07);
	endtask

	task automatic s_standby();
		wr(8'hB8, 8'h00, 8'h1E, 1'b1);
		check({standby, chanEnable}, 8'h08);
		shutdownN = 1'b0;
		wt(12);
		check(torchLevelCode, 8'h00);
		shutdownN = 1'b1;
		wt(12);
		wr(8'h08, 8'h00, 8'hFE, 1'b1);
		check(torchLevelCode, 8'h00);
		rd3(8'h00, 8'h00, 8'h00, 8'h10);
	endtask

	task automatic s_flash();
		cpt_i2c_host_inst.start(7'h28, 1'b0, ack);
		cpt_i2c_host_inst.xfer(8'hEB, 1'b1, b0, ack);
		cpt_i2c_host_inst.xfer(8'hAC, 1'b1, b0, ack);
		cpt_i2c_host_inst.xfer(8'h1E, 1'b1, b0, ack);
		cpt_i2c_host_inst.xfer(8'hA0, 1'b1, b0, ack);
		check(ack, 8'h00);
		cpt_i2c_host_inst.stop();
		wt(20);
		check({targetIsFlash, flashVoltCode, flashTimeoutSel}, 8'h37);
		check({flashLevelCode, chanEnable}, 8'h1D);
		check(pumpGain, cpt_pkg::G15X);
		rd3(8'hEB, 8'hAC, 8'h1E, 8'hB0);
		wr(8'h60, 8'h00, 8'h00, 1'b0);
		check(standby, 8'h01);
		aboveTgt = 1'b0;
		belowHyst = 1'b1;
		wt(12);
		check(pumpOn, 8'h00);
		sinkLow = 1'b1;
		wt(12);
		check(pumpOn, 8'h01);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{sys_clk, rstn, sinkLow, cur400, cur300, aboveTgt, belowVm1, aboveVin} = 8'h00;
		{shutdownN, belowHyst, belowVm1} = 3'h7;
		{mismatches, comparisons, cycles} = '0;
		wt(20);
		rstn = 1'b1;
		wt(20);
		s_regs();
		s_auto();
		s_standby();
		s_flash();
		conclude();
	end
endmodule
`default_nettype wire

/* File: rtl/cpt_ctrl.sv */
// Charge pump gain selection, torch configuration and serial register access
`timescale 1ns/1ps
`default_nettype none
`include "cpt_defs.svh"

// Operation
// - Torch register bits 4..1 hold the torch level code, applied to enabled channels.
// - Torch level code maps monotonically, 0000 zero current, 1111 full level.
// - Write: address with write bit, control byte, optionally flash then torch byte.
// - Read: address with read bit, returns control, flash, torch bytes in order.
// - Only seven-bit slave address 28 hex is answered.
// - Power-on reset clears every register and all control state.
// - Operates only with enable pin high; channels lit only by config enable bits.
// - Torch and flash: pump stops at target, restarts 50 mV below it.
// - High-efficiency torch: restart on low sink voltage, then watch output and sinks.
// - Output more than 1 V below input allows only 1x gain.
// - Output between input minus 1 V and input never selects 2x.
// - Output above input never selects 1x.
// - Output above target with all channels disabled enters standby, pump off.
// - All three channel enable bits zero disable channels; standby follows once output is above target.
// - Target fixed 4.5 V in torch modes, flash voltage field in flash mode.
// - Mode codes 0100, 1000, 1100 start auto-gain charging.
// - Auto-gain start first switches off every programmed LED.
// - Target reached during start: pump stops, LEDs handed back to config registers.
// - Start steps 1x, 1.5x, 2x to keep input current high, ends at target.
// - Start at 1x, or 1.5x above input; 1x to 1.5x near 400 mA.
// - 1.5x to 2x when target unmet below 300 mA, then pump at 2x.
// - Target never reached keeps pumping at 2x until host shuts down.
// - Control bits 7,6,4,3 select mode; low pair auto, 1x, 1.5x, 2x.
// - Control bit 5 one keeps registers, zero clears them after the command.
// - Status bit 4 reads one while output exceeds target.
module cpt_ctrl (
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       shutdownN,
	input  wire logic       scl,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic       outAboveTarget,
	input  wire logic       outBelowHyst,
	input  wire logic       outBelowVinMinus1V,
	input  wire logic       outAboveVin,
	input  wire logic       sinkBelowDropout,
	input  wire logic       inCurBelow400,
	input  wire logic       inCurBelow300,
	output logic            pumpOn,
	output logic [1:0]      pumpGain,
	output logic            pumpPhaseTick,
	output logic [2:0]      chanEnable,
	output logic [3:0]      torchLevelCode,
	output logic [2:0]      flashLevelCode,
	output logic            targetIsFlash,
	output logic [2:0]      flashVoltCode,
	output logic [1:0]      flashTimeoutSel,
	output logic            standby
);
	// ****************************************
	// Input synchronisation
	// ****************************************
	cpt_sync_if #(.W(`CPT_IN_NUM)) syncIf ();
	cpt_sync #(.W(`CPT_IN_NUM)) uSync (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.bus     (syncIf.sync)
	);
	assign syncIf.raw = {inCurBelow300, inCurBelow400, sinkBelowDropout, outAboveVin, outBelowVinMinus1V,
		outBelowHyst, outAboveTarget, shutdownN, sdaIn, scl};

	logic sclS, sdaS, atTarget, belowHyst, lowOut, highOut, sinkLow, cur400, cur300;
	assign sclS      = syncIf.clean[`CPT_IN_SCL];
	assign sdaS      = syncIf.clean[`CPT_IN_SDA];
	assign atTarget  = syncIf.clean[`CPT_IN_AT_TARGET];
	assign belowHyst = syncIf.clean[`CPT_IN_BELOW_HYST];
	assign lowOut    = syncIf.clean[`CPT_IN_BELOW_VINM1];
	assign highOut   = syncIf.clean[`CPT_IN_ABOVE_VIN];
	assign sinkLow   = syncIf.clean[`CPT_IN_SINK_LOW];
	assign cur400    = syncIf.clean[`CPT_IN_CUR_400];
	assign cur300    = syncIf.clean[`CPT_IN_CUR_300];

	logic rstAll;
	assign rstAll = !rstn || !syncIf.clean[`CPT_IN_ENABLE];

	// ****************************************
	// Serial slave and registers
	// ****************************************
	cpt_pkg::cpt_i2c_t i2cSt_q, i2cSt_d;
	logic [7:0] controlWordReg_q, controlWordReg_d, flashConfigReg_q, flashConfigReg_d;
	logic [7:0] torchConfigReg_q, torchConfigReg_d, shift_q, shift_d;
	logic [2:0] flashLevelStatusReg_q, flashLevelStatusReg_d;
	logic [3:0] bitCnt_q, bitCnt_d;
	logic [1:0] byteIdx_q, byteIdx_d;
	logic       readMode_q, readMode_d, wrSeen_q, wrSeen_d, cmdDone_q, cmdDone_d;
	logic       sdaOe_q, sdaOe_d, sclPrev_q, sdaPrev_q;
	logic       sclRise, sclFall, busStart, busStop;
	logic [7:0] rdNext;

	assign sclRise  = sclS && !sclPrev_q;
	assign sclFall  = !sclS && sclPrev_q;
	assign busStart = sclS && sclPrev_q && sdaPrev_q && !sdaS;
	assign busStop  = sclS && sclPrev_q && !sdaPrev_q && sdaS;

	function automatic logic [7:0] readByte(input logic [1:0] idx);
		case (idx)
			2'h0:    readByte = controlWordReg_q;
			2'h1:    readByte = flashConfigReg_q;
			2'h2:    readByte = torchConfigReg_q;
			default: readByte = {flashLevelStatusReg_q, atTarget, 4'h0};
		endcase
	endfunction
	assign rdNext = readByte(byteIdx_q + 2'h1);

	always_comb begin
		i2cSt_d = i2cSt_q;
		controlWordReg_d = controlWordReg_q;
		flashConfigReg_d = flashConfigReg_q;
		torchConfigReg_d = torchConfigReg_q;
		flashLevelStatusReg_d = flashLevelStatusReg_q;
		shift_d = shift_q;
		bitCnt_d = bitCnt_q;
		byteIdx_d = byteIdx_q;
		readMode_d = readMode_q;
		wrSeen_d = wrSeen_q;
		sdaOe_d = sdaOe_q;
		cmdDone_d = 1'b0;
		if (busStart) begin
			i2cSt_d = cpt_pkg::I2C_ADDR;
			bitCnt_d = 4'h0;
			sdaOe_d = 1'b0;
		end else if (busStop) begin
			i2cSt_d = cpt_pkg::I2C_IDLE;
			sdaOe_d = 1'b0;
			if (wrSeen_q) begin
				wrSeen_d = 1'b0;
				cmdDone_d = 1'b1;
				if (!controlWordReg_q[`CPT_CTRL_KEEP]) begin
					controlWordReg_d = `CPT_REG_RESET;
					flashConfigReg_d = `CPT_REG_RESET;
					torchConfigReg_d = `CPT_REG_RESET;
					flashLevelStatusReg_d = 3'h0;
				end
			end
		end else begin
			case (i2cSt_q)
				cpt_pkg::I2C_ADDR, cpt_pkg::I2C_WR: begin
					if (sclRise) begin
						shift_d = {shift_q[6:0], sdaS};
						bitCnt_d = bitCnt_q + 4'h1;
					end else if (sclFall && bitCnt_q == 4'h8) begin
						bitCnt_d = 4'h0;
						if (i2cSt_q == cpt_pkg::I2C_ADDR) begin
							if (shift_q[7:1] == `CPT_SLAVE_ADDR) begin
								i2cSt_d = cpt_pkg::I2C_ACKA;
								sdaOe_d = 1'b1;
								readMode_d = shift_q[0];
								byteIdx_d = 2'h0;
							end else begin
								i2cSt_d = cpt_pkg::I2C_IDLE;
							end
						end else begin
							case (byteIdx_q)
								2'h0:    controlWordReg_d = shift_q;
								2'h1:    flashConfigReg_d = shift_q;
								2'h2:    torchConfigReg_d = shift_q;
								default: flashLevelStatusReg_d = shift_q[`CPT_STAT_FV_MSB:`CPT_STAT_FV_LSB];
							endcase
							if (byteIdx_q != `CPT_BYTE_LAST) begin
								byteIdx_d = byteIdx_q + 2'h1;
							end
							wrSeen_d = 1'b1;
							i2cSt_d = cpt_pkg::I2C_ACKW;
							sdaOe_d = 1'b1;
						end
					end
				end
				cpt_pkg::I2C_ACKA: begin
					if (sclFall) begin
						if (readMode_q) begin
							i2cSt_d = cpt_pkg::I2C_RD;
							shift_d = readByte(2'h0);
							sdaOe_d = !shift_d[7];
							bitCnt_d = 4'h1;
						end else begin
							i2cSt_d = cpt_pkg::I2C_WR;
							sdaOe_d = 1'b0;
						end
					end
				end
				cpt_pkg::I2C_ACKW: begin
					if (sclFall) begin
						i2cSt_d = cpt_pkg::I2C_WR;
						sdaOe_d = 1'b0;
					end
				end
				cpt_pkg::I2C_RD: begin
					if (sclFall) begin
						if (bitCnt_q == 4'h8) begin
							i2cSt_d = cpt_pkg::I2C_RACK;
							sdaOe_d = 1'b0;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							sdaOe_d = !shift_q[6];
							bitCnt_d = bitCnt_q + 4'h1;
						end
					end
				end
				cpt_pkg::I2C_RACK: begin
					if (sclRise && sdaS) begin
						i2cSt_d = cpt_pkg::I2C_IDLE;
					end else if (sclFall) begin
						byteIdx_d = byteIdx_q + 2'h1;
						shift_d = rdNext;
						sdaOe_d = !rdNext[7];
						bitCnt_d = 4'h1;
						i2cSt_d = cpt_pkg::I2C_RD;
					end
				end
				default: i2cSt_d = cpt_pkg::I2C_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rstAll) begin
			i2cSt_q <= cpt_pkg::I2C_IDLE;
			controlWordReg_q <= `CPT_REG_RESET;
			flashConfigReg_q <= `CPT_REG_RESET;
			torchConfigReg_q <= `CPT_REG_RESET;
			flashLevelStatusReg_q <= 3'h0;
			shift_q <= 8'h00;
			bitCnt_q <= 4'h0;
			byteIdx_q <= 2'h0;
			readMode_q <= 1'b0;
			wrSeen_q <= 1'b0;
			cmdDone_q <= 1'b0;
			sdaOe_q <= 1'b0;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else begin
			i2cSt_q <= i2cSt_d;
			controlWordReg_q <= controlWordReg_d;
			flashConfigReg_q <= flashConfigReg_d;
			torchConfigReg_q <= torchConfigReg_d;
			flashLevelStatusReg_q <= flashLevelStatusReg_d;
			shift_q <= shift_d;
			bitCnt_q <= bitCnt_d;
			byteIdx_q <= byteIdx_d;
			readMode_q <= readMode_d;
			wrSeen_q <= wrSeen_d;
			cmdDone_q <= cmdDone_d;
			sdaOe_q <= sdaOe_d;
			sclPrev_q <= sclS;
			sdaPrev_q <= sdaS;
		end
	end

	// ****************************************
	// Mode decode and pump clock
	// ****************************************
	logic [3:0] modeCode;
	logic       isFlash, isHe, isAuto, modeValid;
	logic [2:0] cfgEn;
	logic [2:0] divCnt_q, divCnt_d;
	assign modeCode  = {controlWordReg_q[7:6], controlWordReg_q[4:3]};
	assign isFlash   = controlWordReg_q[7] && controlWordReg_q[6];
	assign isHe      = modeCode == `CPT_MODE_HE_TORCH;
	assign isAuto    = isHe || modeCode == `CPT_MODE_AUTO_TRCH || modeCode == `CPT_MODE_AUTO_FLSH;
	assign modeValid = controlWordReg_q[7] || controlWordReg_q[6];
	assign cfgEn     = isFlash ? flashConfigReg_q[`CPT_CFG_EN_MSB:`CPT_CFG_EN_LSB]
		: torchConfigReg_q[`CPT_CFG_EN_MSB:`CPT_CFG_EN_LSB];

	assign pumpPhaseTick = divCnt_q == 3'(`CPT_PUMP_DIV - 1);
	assign divCnt_d      = pumpPhaseTick ? 3'h0 : divCnt_q + 3'h1;

	function automatic cpt_pkg::cpt_gain_t clampGain(input cpt_pkg::cpt_gain_t g);
		clampGain = g;
		if (lowOut) begin
			clampGain = cpt_pkg::G1X;
		end else if (highOut && g == cpt_pkg::G1X) begin
			clampGain = cpt_pkg::G15X;
		end else if (!highOut && g == cpt_pkg::G2X) begin
			clampGain = cpt_pkg::G15X;
		end
	endfunction

	// ****************************************
	// Gain and pump control
	// ****************************************
	cpt_pkg::cpt_ctl_t  ctlSt_q, ctlSt_d;
	cpt_pkg::cpt_gain_t gain_q, gain_d, reqGain;
	logic pumpOn_q, pumpOn_d, startReq_q, startReq_d, standby_q, standby_d;
	logic [2:0] chanEn_q, chanEn_d;

	always_comb begin
		ctlSt_d = ctlSt_q;
		gain_d = gain_q;
		pumpOn_d = pumpOn_q;
		reqGain = gain_q;
		startReq_d = cmdDone_q ? 1'b1 : (pumpPhaseTick ? 1'b0 : startReq_q);
		standby_d = ctlSt_q == cpt_pkg::ST_RUN && cfgEn == 3'h0 && atTarget;
		if (pumpPhaseTick) begin
			if (startReq_q) begin
				pumpOn_d = 1'b0;
				if (isAuto) begin
					ctlSt_d = cpt_pkg::ST_INIT;
				end else if (modeValid) begin
					ctlSt_d = cpt_pkg::ST_RUN;
				end else begin
					ctlSt_d = cpt_pkg::ST_OFF;
				end
			end else begin
				case (ctlSt_q)
					cpt_pkg::ST_OFF: pumpOn_d = 1'b0;
					cpt_pkg::ST_INIT: begin
						if (atTarget) begin
							ctlSt_d = cpt_pkg::ST_RUN;
						end else begin
							ctlSt_d = cpt_pkg::ST_CHARGE;
							pumpOn_d = 1'b1;
							reqGain = highOut ? cpt_pkg::G15X : cpt_pkg::G1X;
						end
					end
					cpt_pkg::ST_CHARGE: begin
						if (atTarget) begin
							ctlSt_d = cpt_pkg::ST_RUN;
							pumpOn_d = 1'b0;
						end else if (gain_q == cpt_pkg::G1X && cur400) begin
							reqGain = cpt_pkg::G15X;
						end else if (gain_q == cpt_pkg::G15X && cur300) begin
							reqGain = cpt_pkg::G2X;
						end
					end
					cpt_pkg::ST_RUN: begin
						if (atTarget) begin
							pumpOn_d = 1'b0;
						end else if (!pumpOn_q && (isHe ? sinkLow : belowHyst)) begin
							pumpOn_d = 1'b1;
						end
						if (controlWordReg_q[4:3] != 2'h0) begin
							reqGain = cpt_pkg::cpt_gain_t'(controlWordReg_q[4:3]);
						end
					end
					default: ctlSt_d = cpt_pkg::ST_OFF;
				endcase
			end
			gain_d = clampGain(reqGain);
		end
		if (standby_d) begin
			pumpOn_d = 1'b0;
		end
		if (ctlSt_d == cpt_pkg::ST_RUN) begin
			chanEn_d = cfgEn;
		end else begin
			chanEn_d = 3'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rstAll) begin
			ctlSt_q <= cpt_pkg::ST_OFF;
			gain_q <= cpt_pkg::G1X;
			pumpOn_q <= 1'b0;
			startReq_q <= 1'b0;
			standby_q <= 1'b0;
			chanEn_q <= 3'h0;
			divCnt_q <= 3'h0;
		end else begin
			ctlSt_q <= ctlSt_d;
			gain_q <= gain_d;
			pumpOn_q <= pumpOn_d;
			startReq_q <= startReq_d;
			standby_q <= standby_d;
			chanEn_q <= chanEn_d;
			divCnt_q <= divCnt_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sdaOut          = 1'b0;
	assign sdaOe           = sdaOe_q;
	assign pumpOn          = pumpOn_q;
	assign pumpGain        = gain_q;
	assign chanEnable      = chanEn_q;
	assign standby         = standby_q;
	assign torchLevelCode  = torchConfigReg_q[`CPT_TORCH_LVL_MSB:`CPT_TORCH_LVL_LSB];
	assign flashLevelCode  = flashConfigReg_q[`CPT_FLASH_LVL_MSB:`CPT_FLASH_LVL_LSB];
	assign targetIsFlash   = isFlash;
	assign flashVoltCode   = flashLevelStatusReg_q;
	assign flashTimeoutSel = controlWordReg_q[1:0];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rstAll);

	sequence s_tickGap;
		!pumpPhaseTick [*3] ##1 pumpPhaseTick;
	endsequence
	sequence s_gainHeld;
		$stable(gain_q) [*3];
	endsequence
	property p_gainOnTick;
		pumpPhaseTick |=> ##1 s_gainHeld;
	endproperty
	a_gainOnTick: assert property (p_gainOnTick) else $error("gain moved off pump boundary");

	property p_tickPeriod;
		pumpPhaseTick |=> s_tickGap;
	endproperty
	a_tickPeriod: assert property (p_tickPeriod) else $error("pump tick spacing wrong");

	property p_lowOut1x;
		pumpPhaseTick && lowOut |=> gain_q == cpt_pkg::G1X;
	endproperty
	a_lowOut1x: assert property (p_lowOut1x) else $error("gain not 1x with low output");

	property p_midNo2x;
		pumpPhaseTick && !lowOut && !highOut |=> gain_q != cpt_pkg::G2X;
	endproperty
	a_midNo2x: assert property (p_midNo2x) else $error("2x selected below input");

	property p_highNo1x;
		pumpPhaseTick && !lowOut && highOut |=> gain_q != cpt_pkg::G1X;
	endproperty
	a_highNo1x: assert property (p_highNo1x) else $error("1x selected above input");

	property p_ledsOffInStart;
		ctlSt_q == cpt_pkg::ST_INIT || ctlSt_q == cpt_pkg::ST_CHARGE |-> chanEnable == 3'h0;
	endproperty
	a_ledsOffInStart: assert property (p_ledsOffInStart) else $error("LED lit during start");

	sequence s_chargeDone;
		ctlSt_q == cpt_pkg::ST_CHARGE && pumpPhaseTick && atTarget && !startReq_q;
	endsequence
	property p_startEnds;
		s_chargeDone |=> ctlSt_q == cpt_pkg::ST_RUN && !pumpOn && chanEnable == cfgEn;
	endproperty
	a_startEnds: assert property (p_startEnds) else $error("start did not hand back");

	property p_startGain;
		ctlSt_q == cpt_pkg::ST_INIT && pumpPhaseTick && !startReq_q && !atTarget && !highOut
			|=> ctlSt_q == cpt_pkg::ST_CHARGE && pumpOn && gain_q == cpt_pkg::G1X;
	endproperty
	a_startGain: assert property (p_startGain) else $error("start not at 1x");

	property p_stopAtTarget;
		ctlSt_q == cpt_pkg::ST_RUN && pumpPhaseTick && atTarget |=> !pumpOn;
	endproperty
	a_stopAtTarget: assert property (p_stopAtTarget) else $error("pump kept running at target");

	property p_standby;
		standby |-> !pumpOn && chanEnable == 3'h0;
	endproperty
	a_standby: assert property (p_standby) else $error("standby with pump or LED on");

	property p_badAddr;
		i2cSt_q == cpt_pkg::I2C_ADDR && sclFall && bitCnt_q == 4'h8 && shift_q[7:1] != `CPT_SLAVE_ADDR
			&& !busStart && !busStop |=> i2cSt_q == cpt_pkg::I2C_IDLE && !sdaOe;
	endproperty
	a_badAddr: assert property (p_badAddr) else $error("foreign address acknowledged");

	property p_clearOnStop;
		busStop && wrSeen_q && !controlWordReg_q[`CPT_CTRL_KEEP] |=> controlWordReg_q == 8'h00
			&& torchConfigReg_q == 8'h00 && flashConfigReg_q == 8'h00;
	endproperty
	a_clearOnStop: assert property (p_clearOnStop) else $error("registers kept with bit 5 low");
endmodule
`default_nettype wire

/* File: rtl/cpt_defs.svh */
// Constants of the charge pump gain and torch control block
`ifndef CPT_DEFS_SVH
`define CPT_DEFS_SVH

// ****************************************
// Serial bus
// ****************************************
`define CPT_SLAVE_ADDR     7'h28
`define CPT_REG_RESET      8'h00
`define CPT_BYTE_LAST      2'h3

// ****************************************
// Field positions
// ****************************************
`define CPT_CTRL_KEEP      5
`define CPT_CFG_EN_MSB     7
`define CPT_CFG_EN_LSB     5
`define CPT_TORCH_LVL_MSB  4
`define CPT_TORCH_LVL_LSB  1
`define CPT_FLASH_LVL_MSB  4
`define CPT_FLASH_LVL_LSB  2
`define CPT_STAT_FV_MSB    7
`define CPT_STAT_FV_LSB    5

// ****************************************
// Mode codes of control bits 7, 6, 4, 3
// ****************************************
`define CPT_MODE_HE_TORCH  4'h4
`define CPT_MODE_AUTO_TRCH 4'h8
`define CPT_MODE_AUTO_FLSH 4'hC

// ****************************************
// Synchronised input positions
// ****************************************
`define CPT_IN_SCL         0
`define CPT_IN_SDA         1
`define CPT_IN_ENABLE      2
`define CPT_IN_AT_TARGET   3
`define CPT_IN_BELOW_HYST  4
`define CPT_IN_BELOW_VINM1 5
`define CPT_IN_ABOVE_VIN   6
`define CPT_IN_SINK_LOW    7
`define CPT_IN_CUR_400     8
`define CPT_IN_CUR_300     9
`define CPT_IN_NUM         10

// ****************************************
// Timing
// ****************************************
`define CPT_SYS_CLK_HZ     10000000
`define CPT_PUMP_CLK_HZ    2400000
`define CPT_PUMP_DIV       (`CPT_SYS_CLK_HZ / `CPT_PUMP_CLK_HZ)

`endif

/* File: rtl/cpt_pkg.sv */
// Types of the charge pump gain and torch control block
package cpt_pkg;
	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_ACKA = 3'h2,
		I2C_WR   = 3'h3,
		I2C_ACKW = 3'h4,
		I2C_RD   = 3'h5,
		I2C_RACK = 3'h6
	} cpt_i2c_t;

	typedef enum logic [1:0] {
		ST_OFF    = 2'h0,
		ST_INIT   = 2'h1,
		ST_CHARGE = 2'h2,
		ST_RUN    = 2'h3
	} cpt_ctl_t;

	typedef enum logic [1:0] {
		G1X  = 2'h1,
		G15X = 2'h2,
		G2X  = 2'h3
	} cpt_gain_t;
endpackage

/* File: rtl/cpt_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cpt_sync #(parameter int W = 1) (
	input wire logic   sys_clk,
	input wire logic   rstn,
	cpt_sync_if.sync   bus
);
	logic [W-1:0] s1_q, s2_q, s3_q, clean_q;
	logic [W-1:0] clean_d;

	// Change accepted once second and third stage agree
	always_comb begin
		clean_d = clean_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				clean_d[i] = s3_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			clean_q <= '0;
		end else begin
			s1_q    <= bus.raw;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			clean_q <= clean_d;
		end
	end

	assign bus.clean = clean_q;
endmodule
`default_nettype wire

/* File: rtl/cpt_sync_if.sv */
// Raw and filtered input bundle between the control and its synchroniser
`timescale 1ns/1ps
`default_nettype none
interface cpt_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport user (output raw, input clean);
	modport sync (input raw, output clean);
endinterface
`default_nettype wire
